// *** core/eeprom_ctl_pkg.sv ***
// Shared constants and types of the serial EEPROM access controller
package eeprom_ctl_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'ha0;
  localparam logic [7:0] ADDR_DATA_OFFSET = 8'ha4;
  // Control register fields
  localparam int START_BIT = 0;
  localparam int CMD_LSB = 1;
  localparam int AL_STATUS_BIT = 4;
  localparam int AL_DISABLE_BIT = 5;
  localparam int RATE_LSB = 6;
  localparam int STATUS_LSB = 8;
  localparam logic [7:0] STATUS_WR_MASK = 8'h8c;
  localparam logic [2:0] CMD_RESET = 3'h0;
  localparam logic AL_DISABLE_RESET = 1'b1;
  localparam logic [1:0] RATE_RESET = 2'h1;
  // Status byte bits
  localparam int WIP_BIT = 0;
  localparam int WEL_BIT = 1;
  // Command codes, also the serial opcodes
  localparam logic [2:0] CMD_WRSR = 3'h1;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_READ = 3'h3;
  localparam logic [2:0] CMD_WRDI = 3'h4;
  localparam logic [2:0] CMD_RDSR = 3'h5;
  localparam logic [2:0] CMD_WREN = 3'h6;
  // Clock rate codes
  localparam logic [1:0] RATE_DIV64 = 2'h1;
  localparam logic [1:0] RATE_TEST = 2'h3;
  // Serial clock timing
  localparam int CORE_CLK_MHZ = 250;
  localparam int CORE_DIV = 64;
  localparam int PCLK_PERIOD_NS = 8;
  localparam int SCK_PERIOD_NS = CORE_DIV * 1000 / CORE_CLK_MHZ;
  localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * PCLK_PERIOD_NS);
  localparam int TEST_HALF_CYC = 2;
  localparam int HALF_W = 8;
  // Frame lengths in bits
  localparam int FRAME_W = 40;
  localparam int CNT_W = 6;
  localparam logic [5:0] BITS_OPC = 6'h08;
  localparam logic [5:0] BITS_STAT = 6'h10;
  localparam logic [5:0] BITS_WORD = 6'h28;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LAUNCH = 2'b01,
    ST_WAIT = 2'b10,
    ST_FINISH = 2'b11
  } seq_state_t;
endpackage : eeprom_ctl_pkg

// *** core/sck_tick_gen.sv ***
// Half-period tick generator for the serial EEPROM clock
`timescale 1ns/10ps
module sck_tick_gen #(
  parameter int HALF_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [HALF_W-1:0] half_cyc,
  output logic tick
);
  logic [HALF_W-1:0] cnt_r; // Cycles since last tick

  // Count restarts whenever no frame runs, so every frame has even phases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (!run || tick) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Tick on last cycle of each half period
  assign tick = run && (cnt_r == half_cyc - 1'b1);
endmodule : sck_tick_gen

// *** core/serial_frame_shifter.sv ***
// One chip-select frame on the serial EEPROM, mode 0, MSB first
`timescale 1ns/10ps
module serial_frame_shifter #(
  parameter int FRAME_W = 40,
  parameter int CNT_W = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [CNT_W-1:0] nbits,
  input wire logic [FRAME_W-1:0] tx_data,
  input wire logic tick,
  input wire logic miso_s,
  output logic busy,
  output logic done,
  output logic [15:0] rx_data,
  output logic sck,
  output logic mosi,
  output logic cs_n
);
  logic [FRAME_W-1:0] tx_r; // Outgoing bits, MSB on the wire
  logic [CNT_W-1:0] cnt_r; // Bits clocked so far

  // Frame engine: data changes on falling edge, sampled on rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      tx_r <= '0;
      cnt_r <= '0;
      rx_data <= '0;
      sck <= 1'b0;
      mosi <= 1'b0;
      cs_n <= 1'b1;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        cs_n <= 1'b0;
        tx_r <= tx_data << 1;
        mosi <= tx_data[FRAME_W-1];
        cnt_r <= '0;
      end else if (busy && tick && !sck) begin
        // Rising edge: capture one bit
        sck <= 1'b1;
        rx_data <= {rx_data[14:0], miso_s};
        cnt_r <= cnt_r + 1'b1;
      end else if (busy && tick) begin
        // Falling edge: next bit, or close the frame
        sck <= 1'b0;
        if (cnt_r == nbits) begin
          busy <= 1'b0;
          done <= 1'b1;
          cs_n <= 1'b1;
          mosi <= 1'b0;
        end else begin
          mosi <= tx_r[FRAME_W-1];
          tx_r <= tx_r << 1;
        end
      end
    end
  end
endmodule : serial_frame_shifter

// *** core/eeprom_access_ctrl.sv ***
// APB-controlled access to an external serial configuration EEPROM
// How it works
// - Start bit zero launches one access cycle
// - Command field picks the serial operation
// - Autoload status set only after successful load
// - Autoload disable bit, resets set, blocks load
// - Clock rate field sets serial clock divider
// - Bit eight shows write in process
// - Bit nine shows write enable latch
// - Bits ten, eleven hold block protection
// - Bit fifteen write protect; twelve-fourteen read-only
// - Low half of word holds address
// - High half holds data written or read
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
module eeprom_access_ctrl #(
  parameter int AUTOLOAD_WORDS = 8,
  parameter logic [15:0] AUTOLOAD_SIG = 16'h5a3c, // Arbitrary image marker
  parameter int HALF_W = eeprom_ctl_pkg::HALF_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fundamental_reset_pin_n,
  output logic eeprom_sck,
  output logic eeprom_cs_n,
  output logic eeprom_mosi,
  input wire logic eeprom_miso,
  output logic cfg_load_valid,
  output logic [7:0] cfg_load_index,
  output logic [15:0] cfg_load_data,
  output logic autoload_busy
);
  // Software-visible state
  logic start_r; // Access in progress
  logic [2:0] cmd_r; // Selected operation
  logic al_status_r; // Autoload result
  logic al_disable_r; // Autoload suppress
  logic [1:0] rate_r; // Serial clock rate code
  logic [7:0] status_r; // Mirror of the EEPROM status byte
  logic [15:0] addr_r; // EEPROM word address
  logic [15:0] data_r; // Word to write or word read
  logic [31:0] prdata_r; // Read data captured in setup
  // Sequencer
  eeprom_ctl_pkg::seq_state_t state_r;
  logic al_active_r; // Autoload owns the sequencer
  logic [7:0] al_index_r; // Autoload word index, zero is the marker
  logic al_ok_r; // Marker matched
  logic [2:0] frame_cmd; // Command of the current frame
  logic [15:0] frame_addr; // Address of the current frame
  // Synchronisers for the pins
  logic miso_m_r;
  logic miso_s_r;
  logic frst_m_r;
  logic frst_s_r;
  logic frst_d_r; // Delayed copy for edge detect
  logic frst_rise; // Fundamental reset released
  // Frame engine hookup
  logic launch; // One-cycle frame start
  logic [5:0] nbits; // Frame length
  logic [39:0] tx_word; // Frame bits, left aligned
  logic tick;
  logic sh_busy;
  logic sh_done;
  logic [15:0] sh_rx;
  logic [HALF_W-1:0] half_cyc;
  // Bus decode
  logic hit_ctrl;
  logic hit_ad;
  logic wr_acc; // Write taken this edge
  logic sw_start; // Software start request
  logic idle_sw; // Registers open to software writes

  assign hit_ctrl = (paddr == eeprom_ctl_pkg::CTRL_OFFSET);
  assign hit_ad = (paddr == eeprom_ctl_pkg::ADDR_DATA_OFFSET);
  assign wr_acc = psel && penable && pwrite;
  // Writes while a cycle runs are dropped, so the frame sees stable fields
  assign idle_sw = !start_r && !al_active_r;
  assign sw_start = wr_acc && hit_ctrl && idle_sw && pstrb[0] &&
                    pwdata[eeprom_ctl_pkg::START_BIT];

  // Zero-wait slave; data was captured in setup
  assign pready = psel && penable;
  assign pslverr = psel && penable && !hit_ctrl && !hit_ad;
  assign prdata = prdata_r;

  // Pin synchronisers, two stages before any logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miso_m_r <= 1'b0;
      miso_s_r <= 1'b0;
      // Pin idles high, so reset to high: no false release edge after reset
      frst_m_r <= 1'b1;
      frst_s_r <= 1'b1;
      frst_d_r <= 1'b1;
    end else begin
      miso_m_r <= eeprom_miso;
      miso_s_r <= miso_m_r;
      frst_m_r <= fundamental_reset_pin_n;
      frst_s_r <= frst_m_r;
      frst_d_r <= frst_s_r;
    end
  end
  assign frst_rise = frst_s_r && !frst_d_r;

  // Read data capture in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (psel && !penable) begin
      if (hit_ctrl) begin
        prdata_r <= {16'h0000, status_r, rate_r, al_disable_r, al_status_r, cmd_r, start_r};
      end else if (hit_ad) begin
        prdata_r <= {data_r, addr_r};
      end else begin
        prdata_r <= '0;
      end
    end
  end

  // Control fields written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r <= eeprom_ctl_pkg::CMD_RESET;
      al_disable_r <= eeprom_ctl_pkg::AL_DISABLE_RESET;
      rate_r <= eeprom_ctl_pkg::RATE_RESET;
    end else if (wr_acc && hit_ctrl && idle_sw && pstrb[0]) begin
      cmd_r <= pwdata[eeprom_ctl_pkg::CMD_LSB +: 3];
      al_disable_r <= pwdata[eeprom_ctl_pkg::AL_DISABLE_BIT];
      rate_r <= pwdata[eeprom_ctl_pkg::RATE_LSB +: 2];
    end
  end

  // Start bit: software sets, sequencer clears at the end of the cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r <= 1'b0;
    end else if (sw_start) begin
      start_r <= 1'b1;
    end else if (state_r == eeprom_ctl_pkg::ST_FINISH && !al_active_r) begin
      start_r <= 1'b0;
    end
  end

  // Status byte mirror: writable bits from software, rest from the part
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
    end else if (state_r == eeprom_ctl_pkg::ST_FINISH && !al_active_r) begin
      if (frame_cmd == eeprom_ctl_pkg::CMD_RDSR) begin
        status_r <= sh_rx[7:0];
      end else if (frame_cmd == eeprom_ctl_pkg::CMD_WRITE ||
                   frame_cmd == eeprom_ctl_pkg::CMD_WRSR) begin
        // Part starts its internal write and drops its latch
        status_r[eeprom_ctl_pkg::WIP_BIT] <= 1'b1;
        status_r[eeprom_ctl_pkg::WEL_BIT] <= 1'b0;
      end else if (frame_cmd == eeprom_ctl_pkg::CMD_WREN) begin
        status_r[eeprom_ctl_pkg::WEL_BIT] <= 1'b1;
      end else if (frame_cmd == eeprom_ctl_pkg::CMD_WRDI) begin
        status_r[eeprom_ctl_pkg::WEL_BIT] <= 1'b0;
      end
    end else if (wr_acc && hit_ctrl && idle_sw && pstrb[1]) begin
      // Only block protection and write protect are writable
      status_r <= (status_r & ~eeprom_ctl_pkg::STATUS_WR_MASK) |
                  (pwdata[eeprom_ctl_pkg::STATUS_LSB +: 8] &
                   eeprom_ctl_pkg::STATUS_WR_MASK);
    end
  end

  // Address and data word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= '0;
      data_r <= '0;
    end else if (state_r == eeprom_ctl_pkg::ST_FINISH && !al_active_r &&
                 frame_cmd == eeprom_ctl_pkg::CMD_READ) begin
      data_r <= sh_rx;
    end else if (wr_acc && hit_ad && idle_sw) begin
      if (pstrb[0]) begin
        addr_r[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        addr_r[15:8] <= pwdata[15:8];
      end
      if (pstrb[2]) begin
        data_r[7:0] <= pwdata[23:16];
      end
      if (pstrb[3]) begin
        data_r[15:8] <= pwdata[31:24];
      end
    end
  end

  // Frame contents: autoload always reads, software uses its command
  assign frame_cmd = al_active_r ? eeprom_ctl_pkg::CMD_READ : cmd_r;
  assign frame_addr = al_active_r ? {8'h00, al_index_r} : addr_r;

  // Frame length and bits per command
  always_comb begin
    nbits = eeprom_ctl_pkg::BITS_OPC;
    tx_word = {5'b00000, frame_cmd, 32'h0000_0000};
    if (frame_cmd == eeprom_ctl_pkg::CMD_READ) begin
      nbits = eeprom_ctl_pkg::BITS_WORD;
      tx_word = {5'b00000, frame_cmd, frame_addr, 16'h0000};
    end else if (frame_cmd == eeprom_ctl_pkg::CMD_WRITE) begin
      nbits = eeprom_ctl_pkg::BITS_WORD;
      tx_word = {5'b00000, frame_cmd, frame_addr, data_r};
    end else if (frame_cmd == eeprom_ctl_pkg::CMD_WRSR) begin
      nbits = eeprom_ctl_pkg::BITS_STAT;
      tx_word = {5'b00000, frame_cmd, status_r, 24'h000000};
    end else if (frame_cmd == eeprom_ctl_pkg::CMD_RDSR) begin
      nbits = eeprom_ctl_pkg::BITS_STAT;
    end
  end

  // Serial clock rate; reserved codes fall back to the normal divider
  always_comb begin
    if (rate_r == eeprom_ctl_pkg::RATE_TEST) begin
      half_cyc = HALF_W'(eeprom_ctl_pkg::TEST_HALF_CYC);
    end else begin
      half_cyc = HALF_W'(eeprom_ctl_pkg::SCK_HALF_CYC);
    end
  end

  assign launch = (state_r == eeprom_ctl_pkg::ST_LAUNCH);

  // Sequencer: one frame per software start with a defined command, or per autoload word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= eeprom_ctl_pkg::ST_IDLE;
    end else begin
      case (state_r)
        eeprom_ctl_pkg::ST_IDLE: begin
          if (al_active_r) begin
            state_r <= eeprom_ctl_pkg::ST_LAUNCH;
          end else if (start_r) begin
            // Undefined codes finish at once with no frame
            if (cmd_r == eeprom_ctl_pkg::CMD_WRSR || cmd_r == eeprom_ctl_pkg::CMD_WRITE ||
                cmd_r == eeprom_ctl_pkg::CMD_READ || cmd_r == eeprom_ctl_pkg::CMD_WRDI ||
                cmd_r == eeprom_ctl_pkg::CMD_RDSR || cmd_r == eeprom_ctl_pkg::CMD_WREN) begin
              state_r <= eeprom_ctl_pkg::ST_LAUNCH;
            end else begin
              state_r <= eeprom_ctl_pkg::ST_FINISH;
            end
          end
        end
        eeprom_ctl_pkg::ST_LAUNCH: begin
          state_r <= eeprom_ctl_pkg::ST_WAIT;
        end
        eeprom_ctl_pkg::ST_WAIT: begin
          if (sh_done) begin
            state_r <= eeprom_ctl_pkg::ST_FINISH;
          end
        end
        default: begin
          state_r <= eeprom_ctl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Autoload: marker word at zero, then the configuration words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      al_active_r <= 1'b0;
      al_index_r <= '0;
      al_ok_r <= 1'b0;
      al_status_r <= 1'b0;
    end else if (frst_rise && !al_active_r && !start_r && !al_disable_r) begin
      al_active_r <= 1'b1;
      al_index_r <= '0;
      al_status_r <= 1'b0;
    end else if (al_active_r && state_r == eeprom_ctl_pkg::ST_FINISH) begin
      if (al_index_r == 8'h00) begin
        al_ok_r <= (sh_rx == AUTOLOAD_SIG);
        if (sh_rx != AUTOLOAD_SIG) begin
          al_active_r <= 1'b0; // Blank or foreign image: status stays 0
        end
      end
      if (al_index_r == 8'(AUTOLOAD_WORDS)) begin
        al_active_r <= 1'b0;
        al_status_r <= al_ok_r;
      end
      al_index_r <= al_index_r + 1'b1;
    end
  end

  // Configuration word strobe toward the loaded registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_load_valid <= 1'b0;
      cfg_load_index <= '0;
      cfg_load_data <= '0;
    end else begin
      cfg_load_valid <= al_active_r && state_r == eeprom_ctl_pkg::ST_FINISH &&
                        al_index_r != 8'h00;
      if (al_active_r && state_r == eeprom_ctl_pkg::ST_FINISH) begin
        cfg_load_index <= al_index_r - 1'b1;
        cfg_load_data <= sh_rx;
      end
    end
  end
  assign autoload_busy = al_active_r;

  // Serial clock timing
  sck_tick_gen #(.HALF_W(HALF_W)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(sh_busy),
    .half_cyc(half_cyc),
    .tick(tick)
  );

  // Frame engine on the EEPROM pins
  serial_frame_shifter #(
    .FRAME_W(eeprom_ctl_pkg::FRAME_W),
    .CNT_W(eeprom_ctl_pkg::CNT_W)
  ) u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .start(launch),
    .nbits(nbits),
    .tx_data(tx_word),
    .tick(tick),
    .miso_s(miso_s_r),
    .busy(sh_busy),
    .done(sh_done),
    .rx_data(sh_rx),
    .sck(eeprom_sck),
    .mosi(eeprom_mosi),
    .cs_n(eeprom_cs_n)
  );
endmodule : eeprom_access_ctrl

// *** verif/eeprom_access_ctrl_properties.sv ***
// Port-level checks of the EEPROM access controller
`timescale 1ns/10ps
module eeprom_access_ctrl_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic eeprom_sck,
  input wire logic eeprom_cs_n,
  input wire logic eeprom_mosi,
  input wire logic cfg_load_valid,
  input wire logic autoload_busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] hold_r; // Cycles since sck or cs_n last moved
  logic mapped; // Access hits one of the two registers
  assign mapped = (paddr == eeprom_ctl_pkg::CTRL_OFFSET) || (paddr == eeprom_ctl_pkg::ADDR_DATA_OFFSET);
  // Saturating age of the serial clock level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r <= 8'h00;
    end else if ($changed(eeprom_sck) || $changed(eeprom_cs_n)) begin
      hold_r <= 8'h00;
    end else if (hold_r != 8'hff) begin
      hold_r <= hold_r + 8'h01;
    end
  end
  // Frame opening: select falls while the clock idles low
  sequence frame_open_s;
    $fell(eeprom_cs_n) && !eeprom_sck;
  endsequence
  AST_NO_WAIT: assert property (psel && penable |-> pready) else $error("access phase without ready");
  AST_SLVERR: assert property (psel && penable |-> pslverr == !mapped) else $error("bad error flag");
  AST_SCK_IDLE: assert property (eeprom_cs_n |-> !eeprom_sck) else $error("sck moves outside frame");
  AST_SCK_HALF: assert property ($changed(eeprom_sck) && !eeprom_cs_n |-> hold_r == 8'h0f || hold_r == 8'h01)
    else $error("sck half period wrong");
  AST_FRAME_OPEN: assert property (frame_open_s |-> (!eeprom_sck && !eeprom_cs_n) [*2] ##1 !eeprom_cs_n [*8])
    else $error("frame opened badly");
  AST_MOSI_HOLD: assert property (eeprom_sck |-> $stable(eeprom_mosi)) else $error("mosi moved with sck high");
  AST_LOAD_IN_RUN: assert property (cfg_load_valid |-> $past(autoload_busy)) else $error("load word outside autoload");
  AST_LOAD_PULSE: assert property (cfg_load_valid |=> !cfg_load_valid [*8]) else $error("load words too close");
endmodule : eeprom_access_ctrl_properties
bind eeprom_access_ctrl eeprom_access_ctrl_properties chk_u (.pclk, .presetn, .psel, .penable, .paddr, .pready,
  .pslverr, .eeprom_sck, .eeprom_cs_n, .eeprom_mosi, .cfg_load_valid, .autoload_busy);

// *** verif/spi_eeprom_model.sv ***
// Behavioural serial EEPROM, mode 0, word wide
`timescale 1ns/10ps
module spi_eeprom_model #(
  parameter logic [15:0] SIG = 16'h0001, // Image marker in word 0
  parameter int WIP_POLLS = 1 // Status reads that still see a write busy
) (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso
);
  logic [15:0] mem [0:255]; // Words, low address byte only
  logic [39:0] sr = 40'h0; // Shift-in
  logic [15:0] out = 16'ha5a5; // Shift-out, noise when unused
  logic [7:0] stat = 8'h00; // Status byte
  logic [7:0] op; // Opcode of the closing frame
  int cnt = 0; // Bits in this frame
  int left = 0; // Busy polls still to serve
  initial begin
    miso = 1'b1;
    for (int i = 0; i < 256; i++) mem[i] = 16'h1000 + 16'(i * 257);
    mem[0] = SIG;
  end
  always @(negedge cs_n) cnt = 0;
  // Sample on rise; load answer once opcode or address is in
  always @(posedge sck) if (!cs_n) begin
    sr = {sr[38:0], mosi};
    cnt++;
    if (cnt == 8 && sr[7:0] == 8'h05) out = {stat, 8'h00};
    if (cnt == 24 && sr[23:16] == 8'h03) out = mem[sr[7:0]];
  end
  // Launch on fall, ahead of the next rise
  always @(negedge sck) if (!cs_n) begin
    miso = out[15];
    out = {out[14:0], ~out[15]};
  end
  // Commands take effect when the frame closes
  always @(posedge cs_n) begin
    miso = ~miso; // Released line keeps no level
    op = (cnt >= 8) ? 8'(sr >> (cnt - 8)) : 8'hff;
    if (op == 8'h06 && cnt == 8) stat[1] = 1'b1;
    if (op == 8'h04 && cnt == 8) stat[1] = 1'b0;
    if (op == 8'h01 && cnt == 16 && stat[1]) begin
      stat = (stat & 8'h70) | (sr[7:0] & 8'h8c) | 8'h01;
      left = WIP_POLLS;
    end
    if (op == 8'h02 && cnt == 40 && stat[1]) begin
      mem[sr[23:16]] = sr[15:0];
      stat[1:0] = 2'b01;
      left = WIP_POLLS;
    end
    if (op == 8'h05 && cnt == 16) begin
      if (left > 0) left--;
      if (left == 0) stat[0] = 1'b0;
    end
  end
endmodule : spi_eeprom_model

// *** verif/serial_eeprom_access_control_tb.sv ***
// Self-checking bench of the serial EEPROM access controller
`timescale 1ns/10ps
module serial_eeprom_access_control_tb;
  localparam logic [15:0] SIG = 16'h3c5a; // Arbitrary image marker
  localparam int WORDS = 3; // Short autoload image
  localparam logic [7:0] CTL = eeprom_ctl_pkg::CTRL_OFFSET;
  localparam logic [7:0] AD = eeprom_ctl_pkg::ADDR_DATA_OFFSET;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} exp_t; // One expected answer
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fund_n = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata, rd;
  logic pready, pslverr, sck, cs_n, mosi, miso, ld_v, busy;
  logic [7:0] ld_i;
  logic [15:0] ld_d, ea, ed;
  logic [7:0] st = 8'h00; // Status bits sent with each command
  exp_t exp_q[$]; // APB answers in issue order
  logic [31:0] ld_q[$]; // Autoload words {index, data}
  int num_errors = 0, checks_done = 0, frames = 0, n;
  always #4 pclk = ~pclk;
  always @(negedge cs_n) frames++;
  eeprom_access_ctrl #(.AUTOLOAD_WORDS(WORDS), .AUTOLOAD_SIG(SIG)) dut_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .fundamental_reset_pin_n(fund_n),
    .eeprom_sck(sck), .eeprom_cs_n(cs_n), .eeprom_mosi(mosi), .eeprom_miso(miso), .cfg_load_valid(ld_v),
    .cfg_load_index(ld_i), .cfg_load_data(ld_d), .autoload_busy(busy));
  spi_eeprom_model #(.SIG(SIG), .WIP_POLLS(1)) mdl_u (.sck, .cs_n, .mosi, .miso);
  task automatic cmp_data(input logic [31:0] got, input logic [31:0] want, input logic [31:0] mask);
    checks_done++;
    if ((got & mask) !== (want & mask)) begin
      num_errors++;
      $display("BAD %0t data %h expected %h", $time, got, want);
    end
  endtask : cmp_data
  task automatic cmp_err(input logic got, input logic want);
    checks_done++;
    if (got !== want) begin
      num_errors++;
      $display("BAD %0t slave error %b", $time, got);
    end
  endtask : cmp_err
  // Watcher: oldest note against each answer or loaded word
  always @(posedge pclk) begin
    exp_t x;
    if (psel && penable && pready === 1'b1) begin
      x = exp_q.pop_front();
      cmp_err(pslverr, x.e);
      if (!pwrite) cmp_data(prdata, x.d, x.m);
    end
    if (ld_v === 1'b1) cmp_data({8'h0, ld_i, ld_d}, ld_q.size() ? ld_q.pop_front() : 32'hx, '1);
  end
  // One APB transfer; request held until ready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic e = 1'b0);
    exp_q.push_back('{d, m, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Serial command, then poll until start drops
  task automatic cmd(input logic [2:0] c, input logic [1:0] rate = 2'h1);
    apb(1'b1, CTL, {16'h0, st, rate, 2'b10, c, 1'b1}, 32'h0);
    do apb(1'b0, CTL, 32'h0, 32'h0); while (rd[0] !== 1'b0);
  endtask : cmd
  // Pulse the fundamental reset pin and let any autoload finish
  task automatic pulse();
    fund_n <= 1'b0;
    repeat (4) @(posedge pclk);
    fund_n <= 1'b1;
    repeat (8) @(posedge pclk);
    while (busy !== 1'b0) @(posedge pclk);
  endtask : pulse
  task automatic give_verdict();
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  initial begin
    void'($urandom(73));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, CTL, 32'h60, '1);
    apb(0, AD, 32'h0, '1);
    apb(0, 8'ha8, 32'h0, '1, 1'b1);
    apb(1, 8'h10, '1, 32'h0, 1'b1);
    apb(1, CTL, 32'hffff_ff60, 32'h0);
    apb(0, CTL, 32'h8c60, '1);
    ea = 16'($urandom) | 16'h0080; // Keep clear of the autoload words
    ed = 16'($urandom);
    apb(1, AD, {ed, ea}, 32'h0);
    apb(0, AD, {ed, ea}, '1);
    pstrb <= 4'h3;
    apb(1, AD, {~ed, ~ea}, 32'h0);
    pstrb <= 4'hf;
    apb(0, AD, {ed, ~ea}, '1);
    // Write path, busy polling, then read back
    cmd(eeprom_ctl_pkg::CMD_WREN);
    apb(0, CTL, 32'h0200, 32'h0301);
    apb(1, AD, {ed, ea}, 32'h0);
    cmd(eeprom_ctl_pkg::CMD_WRITE, 2'h3);
    apb(0, CTL, 32'h0100, 32'h0301);
    cmd(eeprom_ctl_pkg::CMD_RDSR);
    apb(0, CTL, 32'h0100, 32'h0301);
    cmd(eeprom_ctl_pkg::CMD_RDSR);
    apb(0, CTL, 32'h0000, 32'h0301);
    apb(1, AD, {~ed, ea}, 32'h0);
    cmd(eeprom_ctl_pkg::CMD_READ);
    apb(0, AD, {ed, ea}, '1);
    // Status byte out and back in
    st = 8'h8c;
    cmd(eeprom_ctl_pkg::CMD_WREN);
    cmd(eeprom_ctl_pkg::CMD_WRSR);
    apb(0, CTL, 32'h8d00, 32'hff01);
    cmd(eeprom_ctl_pkg::CMD_RDSR);
    apb(0, CTL, 32'h8d00, 32'hff01);
    cmd(eeprom_ctl_pkg::CMD_RDSR);
    cmd(eeprom_ctl_pkg::CMD_WRDI, 2'h2);
    st = 8'h00;
    cmd(eeprom_ctl_pkg::CMD_RDSR);
    apb(0, CTL, 32'h8c00, 32'hff01);
    // Undefined codes launch no frame
    n = frames;
    cmd(3'h7);
    cmd(3'h0);
    cmp_data(32'(frames), 32'(n), '1);
    // Autoload: good image, bad marker, disabled
    for (int i = 0; i < WORDS; i++) ld_q.push_back({16'(i), 16'h1000 + 16'((i + 1) * 257)});
    apb(1, CTL, 32'h40, 32'h0);
    pulse();
    apb(0, CTL, 32'h10, 32'h31);
    cmp_data(32'(ld_q.size()), 32'h0, '1);
    mdl_u.mem[0] = ~SIG;
    pulse();
    apb(0, CTL, 32'h00, 32'h31);
    apb(1, CTL, 32'h60, 32'h0);
    n = frames;
    pulse();
    cmp_data(32'(frames), 32'(n), '1);
    give_verdict();
  end
  // Hang guard, far beyond the expected run
  initial begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    give_verdict();
  end
endmodule : serial_eeprom_access_control_tb
